// >>> hdl/rmfu_target.sv
// ROM-mode flash update target: I2C target on the link clock, mode
// and seal state on the reference clock.
// Assumes SCL/SDA arrive unsynchronised and SDA is open drain outside.
`timescale 1ns/1ps
module rmfu_target import rmfu_pkg::*; #(
   parameter logic [15:0] UNSEAL_LO = 16'h1234, // arbitrary
   parameter logic [15:0] UNSEAL_HI = 16'h5678, // arbitrary
   parameter logic [15:0] FULL_LO = 16'h9ABC, // arbitrary
   parameter logic [15:0] FULL_HI = 16'hDEF0, // arbitrary
   parameter logic SEALED_RST = 1'b1,
   parameter logic LOCKED_RST = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic rom_mode_o,
   output logic sealed_o,
   output logic locked_o
);

   ////////////////////////////////////////////////////////////////////
   // Link-domain reset, released synchronously
   logic [1:0] lrst_reg;
   logic lrst_n;
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lrst_reg <= 2'b00;
      end else begin
         lrst_reg <= {lrst_reg[0], 1'b1};
      end
   end
   assign lrst_n = lrst_reg[1];

   ////////////////////////////////////////////////////////////////////
   // Link domain: pin sync, I2C target, register file
   logic [2:0] scl_s_reg, sda_s_reg;
   logic scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
   logic scl_p_reg, sda_p_reg;
   rmfu_st_t st_reg, st_next;
   logic [2:0] cnt_reg, cnt_next;
   logic full_reg, full_next;
   logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next;
   logic rw_reg, rw_next, drv_reg, drv_next;
   logic oe_n_reg;
   logic [7:0] ctl_lo_reg, ctl_lo_next, probe_reg, probe_next;
   logic [15:0] word_reg, word_next;
   logic tog_reg, tog_next;
   rmfu_mode_t ml_s1_reg, ml_reg;
   logic rise, fall, start, stop, hit;
   logic [7:0] rdata;
   logic [7:0] my_addr;

   // Change counts only once the second and third stages agree
   always_comb begin
      scl_f_next = (scl_s_reg[1] == scl_s_reg[2]) ? scl_s_reg[2] : scl_f_reg;
      sda_f_next = (sda_s_reg[1] == sda_s_reg[2]) ? sda_s_reg[2] : sda_f_reg;
   end

   assign rise = scl_f_reg & ~scl_p_reg;
   assign fall = ~scl_f_reg & scl_p_reg;
   assign start = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg;
   assign stop = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg;
   assign my_addr = ml_reg.rom ? ADDR_ROM : ADDR_NORM;
   assign hit = (sh_reg[7:1] == my_addr[7:1]);

   // Read byte: seal and lock flags at control high, probe byte at REG_PROBE, zero elsewhere
   always_comb begin
      rdata = REG_ZERO;
      if (ptr_reg == REG_CTL_HI) begin
         rdata[SEAL_BIT] = ml_reg.sealed;
         rdata[LOCK_BIT] = ml_reg.locked;
      end else if (ptr_reg == REG_PROBE) begin
         rdata = probe_reg;
      end
   end

   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      full_next = full_reg;
      sh_next = sh_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      drv_next = drv_reg;
      ctl_lo_next = ctl_lo_reg;
      probe_next = probe_reg;
      word_next = word_reg;
      tog_next = tog_reg;
      if (start) begin
         st_next = S_ADDR;
         cnt_next = 3'h0;
         full_next = 1'b0;
         drv_next = 1'b0;
      end else if (stop) begin
         st_next = S_IDLE;
         drv_next = 1'b0;
      end else if (rise) begin
         if (st_reg == S_RACK) begin
            if (sda_f_reg) begin
               st_next = S_IDLE;
            end
         end else if (st_reg inside {S_ADDR, S_REG, S_WR, S_RD}) begin
            sh_next = {sh_reg[6:0], sda_f_reg};
            full_next = (cnt_reg == BIT_LAST);
            cnt_next = cnt_reg + 3'h1;
         end
      end else if (fall) begin
         unique case (st_reg)
            S_IDLE: begin
            end
            S_ADDR: if (full_reg) begin
               full_next = 1'b0;
               if (hit) begin
                  rw_next = sh_reg[0];
                  drv_next = 1'b1;
                  st_next = S_AACK;
               end else begin
                  st_next = S_IDLE;
               end
            end
            S_AACK: if (rw_reg) begin
               sh_next = rdata;
               drv_next = ~rdata[7];
               st_next = S_RD;
            end else begin
               drv_next = 1'b0;
               st_next = S_REG;
            end
            S_REG: if (full_reg) begin
               full_next = 1'b0;
               ptr_next = sh_reg;
               drv_next = 1'b1;
               st_next = S_WACK;
            end
            S_WACK: begin
               drv_next = 1'b0;
               st_next = S_WR;
            end
            S_WR: if (full_reg) begin
               full_next = 1'b0;
               drv_next = 1'b1;
               st_next = S_WACK;
               ptr_next = ptr_reg + 8'h01;
               if (ptr_reg == REG_CTL_LO) begin
                  ctl_lo_next = sh_reg;
               end else if (ptr_reg == REG_CTL_HI) begin
                  // Word leaves on toggle
                  word_next = {sh_reg, ctl_lo_reg};
                  tog_next = ~tog_reg;
               end else if (ptr_reg == REG_PROBE && ml_reg.rom) begin
                  probe_next = sh_reg;
               end
            end
            S_RD: if (full_reg) begin
               full_next = 1'b0;
               drv_next = 1'b0;
               ptr_next = ptr_reg + 8'h01;
               st_next = S_RACK;
            end else begin
               // Rise already shifted, so the next bit sits at the top
               drv_next = ~sh_reg[7];
            end
            S_RACK: begin
               sh_next = rdata;
               drv_next = ~rdata[7];
               st_next = S_RD;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         scl_s_reg <= 3'h7;
         sda_s_reg <= 3'h7;
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
         st_reg <= S_IDLE;
         cnt_reg <= 3'h0;
         full_reg <= 1'b0;
         sh_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         drv_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         ctl_lo_reg <= 8'h00;
         probe_reg <= PROBE_RST;
         word_reg <= 16'h0000;
         tog_reg <= 1'b0;
         ml_s1_reg <= '0;
         ml_reg <= '0;
      end else begin
         scl_s_reg <= {scl_s_reg[1:0], scl_i};
         sda_s_reg <= {sda_s_reg[1:0], sda_i};
         scl_f_reg <= scl_f_next;
         sda_f_reg <= sda_f_next;
         scl_p_reg <= scl_f_reg;
         sda_p_reg <= sda_f_reg;
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         full_reg <= full_next;
         sh_reg <= sh_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         drv_reg <= drv_next;
         // Own flop so the pin enable leaves no gate after the register
         oe_n_reg <= ~drv_next;
         ctl_lo_reg <= ctl_lo_next;
         probe_reg <= probe_next;
         word_reg <= word_next;
         tog_reg <= tog_next;
         ml_s1_reg <= '{sealed_o, locked_o, rom_mode_o};
         ml_reg <= ml_s1_reg;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_n_o = oe_n_reg;

   ////////////////////////////////////////////////////////////////////
   // Core domain: mode and seal state
   logic [1:0] ts_reg;
   logic seen_reg, seen_next, ev;
   logic half_reg, half_next;
   rmfu_mode_t m_reg, m_next;

   assign ev = ts_reg[1] ^ seen_reg;

   // Word changes with its toggle and is stable only two or three cycles before ev
   always_comb begin
      m_next = m_reg;
      half_next = half_reg;
      seen_next = ts_reg[1];
      if (ev && !m_reg.rom) begin
         half_next = 1'b0;
         if (word_reg == CMD_ROM && !m_reg.sealed) begin
            m_next.rom = 1'b1;
         end else if (half_reg) begin
            // Halves must be back to back
            if (m_reg.sealed && word_reg == UNSEAL_HI) begin
               m_next.sealed = 1'b0;
            end else if (!m_reg.sealed && m_reg.locked &&
                         word_reg == FULL_HI) begin
               m_next.locked = 1'b0;
            end
         end else begin
            half_next = m_reg.sealed ? (word_reg == UNSEAL_LO)
                      : (m_reg.locked && word_reg == FULL_LO);
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ts_reg <= 2'b00;
         seen_reg <= 1'b0;
         half_reg <= 1'b0;
         m_reg <= '{SEALED_RST, LOCKED_RST, 1'b0};
      end else begin
         ts_reg <= {ts_reg[0], tog_reg};
         seen_reg <= seen_next;
         half_reg <= half_next;
         m_reg <= m_next;
      end
   end

   assign rom_mode_o = m_reg.rom;
   assign sealed_o = m_reg.sealed;
   assign locked_o = m_reg.locked;

   ////////////////////////////////////////////////////////////////////
   // Checks
   a_rom_enter: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      ev && !m_reg.rom && !m_reg.sealed && word_reg == CMD_ROM
      |=> m_reg.rom) else $error("ROM entry missed");
   a_sealed_stay: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      m_reg.sealed && !m_reg.rom |=> !m_reg.rom)
      else $error("ROM entered while sealed");
   a_unseal_pair: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(m_reg.sealed) |-> $past(half_reg) && $past(ev))
      else $error("Unseal without key pair");
   a_lock_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(m_reg.locked) |-> !$past(m_reg.sealed))
      else $error("Full access before unseal");
   a_ack_addr: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
      st_reg == S_ADDR && fall && full_reg && hit |=> st_reg == S_AACK
      && drv_reg) else $error("Own address not acked");
   a_addr_mode: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
      st_reg == S_AACK && $past(st_reg) == S_ADDR |-> $past(sh_reg[7:1]) ==
      ($past(ml_reg.rom) ? ADDR_ROM[7:1] : ADDR_NORM[7:1]))
      else $error("Wrong address acked");
   a_probe_ro: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
      !ml_reg.rom |=> probe_reg == $past(probe_reg))
      else $error("Probe written in firmware mode");
   a_status_bits: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
      ptr_reg == REG_CTL_HI |-> rdata[SEAL_BIT] == ml_reg.sealed &&
      rdata[LOCK_BIT] == ml_reg.locked)
      else $error("Status byte wrong");
   a_ctl_send: assert property (@(posedge link_clk_i) disable iff (!lrst_n)
      st_reg == S_WR && fall && full_reg && ptr_reg == REG_CTL_HI
      |=> tog_reg != $past(tog_reg))
      else $error("Control word not sent");
   c_rom: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(m_reg.rom));
   c_unseal: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(m_reg.sealed));
   c_unlock: cover property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(m_reg.locked));
   c_read: cover property (@(posedge link_clk_i) disable iff (!lrst_n)
      st_reg == S_RACK);
endmodule

// >>> hdl/rmfu_pkg.sv
// Constants and types for the ROM-mode flash update target.
// Assumes one control word path and one I2C target on the link clock.
package rmfu_pkg;
   // 8-bit target addresses, R/W bit in bit 0
   localparam logic [7:0] ADDR_NORM = 8'hAA;
   localparam logic [7:0] ADDR_ROM = 8'h16;
   // Register map
   localparam logic [7:0] REG_CTL_LO = 8'h00;
   localparam logic [7:0] REG_CTL_HI = 8'h01;
   localparam logic [7:0] REG_PROBE = 8'h04;
   localparam logic [7:0] PROBE_RST = 8'h00;
   localparam logic [7:0] REG_ZERO = 8'h00;
   // Control word that switches to ROM mode
   localparam logic [15:0] CMD_ROM = 16'h0F00;
   // Status bit positions in the control-high readback byte
   localparam int SEAL_BIT = 5;
   localparam int LOCK_BIT = 6;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef struct packed {
      logic sealed;
      logic locked;
      logic rom;
   } rmfu_mode_t;

   typedef enum {
      S_IDLE, S_ADDR, S_AACK, S_REG, S_WACK, S_WR, S_RD, S_RACK
   } rmfu_st_t;
endpackage

// >>> bench/rmfu_host.sv
// Host I2C master model facing the update target.
// Assumes the bench resolves open-drain SDA with a pull-up.
`timescale 1ns/1ps
module rmfu_host (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_pull_o
);
   // Slow enough for the target's three-flop pin filter
   localparam time Q = 1000;
   // One millisecond for wait rows
   localparam time MS = 1000000;
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   task automatic bit_io(input logic b, output logic s);
      sda_pull_o = ~b;
      #Q scl_o = 1'b1;
      #(2*Q) s = sda_i;
      scl_o = 1'b0;
      #Q;
   endtask
   task automatic start();
      @(negedge clk_i);
      sda_pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_pull_o = 1'b0;
      #Q;
   endtask
   task automatic xfer(input logic [7:0] w, output logic [7:0] r,
                       input logic ack_in, output logic ack_seen);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], r[i]);
      end
      bit_io(ack_in, s);
      ack_seen = ~s;
   endtask
   // Ok low flags a missing acknowledge to the caller
   task automatic wr(input logic [7:0] dev, rg, input logic [7:0] q[$],
                     output logic ok);
      logic [7:0] r;
      logic a;
      start();
      xfer(dev, r, 1'b1, ok);
      if (ok) begin
         xfer(rg, r, 1'b1, a);
         ok &= a;
         foreach (q[i]) begin
            xfer(q[i], r, 1'b1, a);
            ok &= a;
         end
      end
      stop();
   endtask
   task automatic rd(input logic [7:0] dev, rg, output logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a;
      d = 8'h00;
      start();
      xfer(dev, r, 1'b1, ok);
      if (ok) begin
         xfer(rg, r, 1'b1, a);
         start();
         xfer(dev | 8'h01, r, 1'b1, a);
         ok &= a;
         xfer(8'hFF, d, 1'b1, a);
      end
      stop();
   endtask
   // Row: kind (0 write, 1 compare, 2 wait ms), address, register, byte
   task automatic replay(input logic [25:0] s[$], input int limit,
                         output int tries, output logic done);
      logic [7:0] d;
      logic ok;
      logic bad;
      done = 1'b0;
      tries = 0;
      while (!done && tries < limit) begin
         tries++;
         bad = 1'b0;
         foreach (s[i]) begin
            if (!bad) begin
               case (s[i][25:24])
                  2'h0: begin
                     wr(s[i][23:16], s[i][15:8], '{s[i][7:0]}, ok);
                     bad = !ok;
                  end
                  2'h1: begin
                     rd(s[i][23:16], s[i][15:8], d, ok);
                     bad = !ok || (d !== s[i][7:0]);
                  end
                  default: begin
                     repeat (s[i][7:0]) #(MS);
                  end
               endcase
            end
         end
         done = !bad;
      end
   endtask
endmodule

// >>> bench/rmfu_target_tb.sv
// Self-checking bench for the ROM-mode update target.
// Assumes the host model drives SCL and pulls SDA low only.
`timescale 1ns/1ps
module rmfu_target_tb import rmfu_pkg::*;;
   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] rg;
      logic rd;
      logic [15:0] wd;
      logic ack;
      logic [7:0] rdv;
   } rmfu_row_t;
   // Key values are arbitrary
   localparam logic [15:0] UL = 16'hA1B2;
   localparam logic [15:0] UH = 16'hC3D4;
   localparam logic [15:0] FL = 16'h5E6F;
   localparam logic [15:0] FH = 16'h7081;
   logic ref_clk_i, nrst_i, link_clk, scl, sda, sda_pull, sda_o, sda_oe_n;
   logic rom, sealed, locked, ok;
   logic [7:0] d;
   int n_errors = 0;
   int check_count = 0;
   int tries;
   rmfu_row_t rows[8] = '{
      '{8'h16, 8'h00, 1'b1, 16'h0000, 1'b0, 8'h00},
      '{8'h50, 8'h00, 1'b1, 16'h0000, 1'b0, 8'h00},
      '{8'hAA, 8'h04, 1'b0, 16'h005A, 1'b1, 8'h00},
      '{8'hAA, 8'h04, 1'b1, 16'h0000, 1'b1, 8'h00},
      '{8'hAA, 8'h00, 1'b0, 16'h0000, 1'b1, 8'h00},
      '{8'hAA, 8'h01, 1'b1, 16'h0000, 1'b1, 8'h60},
      '{8'hAA, 8'h00, 1'b0, 16'h0F00, 1'b1, 8'h00},
      '{8'hAA, 8'h00, 1'b1, 16'h0000, 1'b1, 8'h00}};
   assign sda = (sda_oe_n | sda_o) & ~sda_pull;
   rmfu_target #(.UNSEAL_LO(UL), .UNSEAL_HI(UH), .FULL_LO(FL),
      .FULL_HI(FH)) u_rmfu_target (.ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .rom_mode_o(rom),
      .sealed_o(sealed), .locked_o(locked));
   rmfu_host u_rmfu_host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_pull_o(sda_pull));
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      link_clk = 1'b0;
      #17;
      forever #62.5 link_clk = ~link_clk;
   end
   task automatic check(input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Link side resets asynchronously with the core
   task automatic do_reset();
      nrst_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      nrst_i = 1'b1;
      repeat (10) @(negedge ref_clk_i);
   endtask
   // One key half or word per transaction, nothing in between
   task automatic ctl(input logic [15:0] w);
      u_rmfu_host.wr(8'hAA, 8'h00, '{w[7:0], w[15:8]}, ok);
      check(ok, 1'b1);
      repeat (5) @(negedge ref_clk_i);
   endtask
   task automatic seal_rd(input logic [7:0] exp);
      u_rmfu_host.rd(8'hAA, 8'h01, d, ok);
      check(d, exp);
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      n_errors++;
      report_and_stop();
   end
   initial begin
      nrst_i = 1'b0;
      do_reset();
      check({rom, sealed, locked, sda_oe_n}, 4'b0111);
      foreach (rows[i]) begin
         if (rows[i].rd) begin
            u_rmfu_host.rd(rows[i].dev, rows[i].rg, d, ok);
            if (rows[i].ack) begin
               check(d, rows[i].rdv);
            end
         end else begin
            u_rmfu_host.wr(rows[i].dev, rows[i].rg,
               '{rows[i].wd[7:0], rows[i].wd[15:8]}, ok);
         end
         check(ok, rows[i].ack);
      end
      check(rom, 1'b0);
      ctl(UL);
      ctl(16'h0000);
      ctl(UH);
      check(sealed, 1'b1);
      ctl(UL);
      ctl(UH);
      check({sealed, locked}, 2'b01);
      seal_rd(8'h40);
      ctl(FL);
      ctl(FH);
      check(locked, 1'b0);
      seal_rd(8'h00);
      u_rmfu_host.wr(8'hAA, 8'h00, '{8'h00}, ok);
      u_rmfu_host.wr(8'hAA, 8'h01, '{8'h0F}, ok);
      repeat (5) @(negedge ref_clk_i);
      check(rom, 1'b1);
      u_rmfu_host.rd(8'hAA, 8'h04, d, ok);
      check(ok, 1'b0);
      u_rmfu_host.rd(8'h16, 8'h04, d, ok);
      check({ok, d}, 9'h100);
      u_rmfu_host.wr(8'h16, 8'h04, '{~d}, ok);
      u_rmfu_host.rd(8'h16, 8'h04, d, ok);
      check(d, 8'hFF);
      // Good stream passes at once; a bad compare restarts to the limit
      u_rmfu_host.replay('{{2'h0, 8'h16, 8'h04, 8'h3C},
         {2'h2, 8'h00, 8'h00, 8'h01}, {2'h1, 8'h16, 8'h04, 8'h3C}}, 3,
         tries, ok);
      check({ok, tries[7:0]}, 9'h101);
      u_rmfu_host.replay('{{2'h0, 8'h16, 8'h04, 8'h5A},
         {2'h1, 8'h16, 8'h04, 8'hA5}}, 3, tries, ok);
      check({ok, tries[7:0]}, 9'h003);
      u_rmfu_host.rd(8'h16, 8'h04, d, ok);
      check(d, 8'h5A);
      check(rom, 1'b1);
      do_reset();
      check({rom, sealed}, 2'b01);
      ctl(UL);
      ctl(UH);
      ctl(CMD_ROM);
      check(rom, 1'b1);
      report_and_stop();
   end
endmodule
